// [seq_roi_pkg.sv]
// constants and carrier types for the sequenced roi parameter table
`default_nettype none
package seq_roi_pkg;

	////////////////////////////////////////////////////////////////////////
	// table size
	localparam int NUM_IDX_DEF = 128;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] ADDR_INDEX = 8'h00;
	localparam logic [7:0] ADDR_HEIGHT = 8'h04;
	localparam logic [7:0] ADDR_VOFF = 8'h08;
	localparam logic [7:0] ADDR_GAIN = 8'h0c;
	localparam logic [7:0] ADDR_EXPOSURE = 8'h10;
	localparam logic [7:0] ADDR_HBIN = 8'h14;
	localparam logic [7:0] ADDR_WIDTH = 8'h18;
	localparam logic [7:0] ADDR_NEXT = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h20;

	// status register bit positions
	localparam int STAT_MONO_BIT = 0;
	localparam int STAT_TRIG_BIT = 1;
	localparam int STAT_REJECT_BIT = 2;

	////////////////////////////////////////////////////////////////////////
	// value limits (23 bits covers the widest field)
	localparam logic [22:0] HEIGHT_MIN = 23'h2;
	localparam logic [22:0] HEIGHT_MAX = 23'h4c0;
	localparam logic [22:0] VOFF_MIN = 23'h0;
	localparam logic [22:0] VOFF_MAX = 23'h4be;
	localparam logic [22:0] GAIN_MIN = 23'h64;
	localparam logic [22:0] GAIN_MAX = 23'h640;
	localparam logic [22:0] EXPO_MIN = 23'hf;
	localparam logic [22:0] EXPO_MAX = 23'h7a1200;
	localparam logic [22:0] HBIN_MIN = 23'h1;
	localparam logic [22:0] HBIN_MAX = 23'h2;
	localparam logic [22:0] WIDTH_MIN = 23'h60;
	localparam logic [22:0] WIDTH_MAX = 23'h790;
	localparam logic [22:0] IDX_MIN = 23'h1;

	// binning codes
	localparam logic [1:0] HBIN_OFF = 2'h1;
	localparam logic [1:0] HBIN_X2 = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// one table entry
	typedef struct packed {
		logic [10:0] height;
		logic [10:0] voff;
		logic [10:0] gain;
		logic [22:0] exposure;
		logic [1:0] hbin;
		logic [10:0] width;
		logic [7:0] next_idx;
	} param_set_t;

	// values after reset
	localparam param_set_t PARAM_RESET = '{
		height: 11'h4c0,
		voff: 11'h0,
		gain: 11'h0,
		exposure: 23'h4650,
		hbin: 2'h1,
		width: 11'h790,
		next_idx: 8'h1
	};
	localparam logic [7:0] INDEX_RESET = 8'h1;

endpackage
`default_nettype wire

// [seq_roi_param_table.sv]
// per-index roi parameter table with apb register access
//
// Contract
// - keep height per index 1..128, accept 2..1216, reset value 1216
// - keep vertical offset per index, accept 0..1214, reset value 0
// - keep gain per index, accept 100..1600, reset value 0
// - keep exposure per index, accept 15..8000000, reset value 18000
// - horizontal binning: 1 means off, 2 means two-to-one, reset value 1
// - horizontal binning takes effect only on the monochrome model
// - every parameter readable and writable; write sets, read queries
// - keep width per index, accept 96..1936, reset value 1936
// - keep next index per index, 1..128, reset 1, used only in trigger sequence
//
// The register addresses and the APB register port were decided locally.
`default_nettype none
module seq_roi_param_table
	import seq_roi_pkg::*;
#(
	parameter int NUM_IDX = NUM_IDX_DEF
)(
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// camera state
	input wire logic i_mono_model,
	input wire logic i_trig_seq_mode,
	input wire logic [7:0] i_active_index,
	// parameters of the running index
	output param_set_t o_active,
	output logic [7:0] o_next_index
);

	////////////////////////////////////////////////////////////////////////
	// elaboration check: indices are one-based and the entry select is seven bits wide
	if (NUM_IDX < 1 || NUM_IDX > 128)
	begin : g_bad_size
		$error("NUM_IDX must lie in 1..128");
	end

	localparam logic [22:0] IDX_MAX = 23'(NUM_IDX);

	param_set_t tbl_r [NUM_IDX];
	logic [7:0] index_r;
	logic pready_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic reject_r;
	param_set_t active_r;
	logic [7:0] next_index_r;

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic addr_mapped(input logic [7:0] a);
		case (a)
			ADDR_INDEX, ADDR_HEIGHT, ADDR_VOFF, ADDR_GAIN, ADDR_EXPOSURE,
			ADDR_HBIN, ADDR_WIDTH, ADDR_NEXT, ADDR_STATUS: addr_mapped = 1'b1;
			default: addr_mapped = 1'b0;
		endcase
	endfunction

	// true when the written value lies inside the window of its register
	function automatic logic value_ok(input logic [7:0] a, input logic [31:0] d);
		logic [22:0] v;
		logic hi_zero;
		v = d[22:0];
		hi_zero = (d[31:23] == 9'h0);
		case (a)
			ADDR_INDEX, ADDR_NEXT: value_ok = hi_zero && v >= IDX_MIN && v <= IDX_MAX;
			ADDR_HEIGHT: value_ok = hi_zero && v >= HEIGHT_MIN && v <= HEIGHT_MAX;
			ADDR_VOFF: value_ok = hi_zero && v >= VOFF_MIN && v <= VOFF_MAX;
			ADDR_GAIN: value_ok = hi_zero && v >= GAIN_MIN && v <= GAIN_MAX;
			ADDR_EXPOSURE: value_ok = hi_zero && v >= EXPO_MIN && v <= EXPO_MAX;
			ADDR_HBIN: value_ok = hi_zero && v >= HBIN_MIN && v <= HBIN_MAX;
			ADDR_WIDTH: value_ok = hi_zero && v >= WIDTH_MIN && v <= WIDTH_MAX;
			default: value_ok = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// apb handshake: one wait state, so read data comes from a flop

	wire logic access = i_psel && i_penable;
	wire logic first_cycle = access && !pready_r;
	wire logic done = access && pready_r;
	wire logic [6:0] sel = 7'(index_r - 8'h1);
	wire logic req_err = !addr_mapped(i_paddr) || (i_pwrite && !value_ok(i_paddr, i_pwdata));
	wire logic wr_ok = done && i_pwrite && !pslverr_r;

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else if (i_ce)
		begin
			pready_r <= first_cycle;
			pslverr_r <= first_cycle && req_err;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			prdata_r <= 32'h0;
		else if (i_ce && first_cycle)
		begin
			case (i_paddr)
				ADDR_INDEX: prdata_r <= {24'h0, index_r};
				ADDR_HEIGHT: prdata_r <= {21'h0, tbl_r[sel].height};
				ADDR_VOFF: prdata_r <= {21'h0, tbl_r[sel].voff};
				ADDR_GAIN: prdata_r <= {21'h0, tbl_r[sel].gain};
				ADDR_EXPOSURE: prdata_r <= {9'h0, tbl_r[sel].exposure};
				ADDR_HBIN: prdata_r <= {30'h0, tbl_r[sel].hbin};
				ADDR_WIDTH: prdata_r <= {21'h0, tbl_r[sel].width};
				ADDR_NEXT: prdata_r <= {24'h0, tbl_r[sel].next_idx};
				ADDR_STATUS: prdata_r <= {29'h0, reject_r, i_trig_seq_mode, i_mono_model};
				default: prdata_r <= 32'h0;
			endcase
		end
	end

	assign o_pready = pready_r;
	assign o_pslverr = pslverr_r;
	assign o_prdata = prdata_r;

	////////////////////////////////////////////////////////////////////////
	// index select and refusal flag

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			index_r <= INDEX_RESET;
		else if (i_ce && wr_ok && i_paddr == ADDR_INDEX)
			index_r <= i_pwdata[7:0];
	end

	// flag stays until a later write is accepted
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			reject_r <= 1'b0;
		else if (i_ce && done && i_pwrite)
			reject_r <= pslverr_r;
	end

	////////////////////////////////////////////////////////////////////////
	// parameter table

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			for (int i = 0; i < NUM_IDX; i++)
				tbl_r[i] <= PARAM_RESET;
		end
		else if (i_ce && wr_ok)
		begin
			case (i_paddr)
				ADDR_HEIGHT: tbl_r[sel].height <= i_pwdata[10:0];
				ADDR_VOFF: tbl_r[sel].voff <= i_pwdata[10:0];
				ADDR_GAIN: tbl_r[sel].gain <= i_pwdata[10:0];
				ADDR_EXPOSURE: tbl_r[sel].exposure <= i_pwdata[22:0];
				ADDR_HBIN: tbl_r[sel].hbin <= i_pwdata[1:0];
				ADDR_WIDTH: tbl_r[sel].width <= i_pwdata[10:0];
				ADDR_NEXT: tbl_r[sel].next_idx <= i_pwdata[7:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// running index lookup, one cycle behind i_active_index

	wire logic [6:0] act = 7'(i_active_index - 8'h1);

	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			active_r <= PARAM_RESET;
			next_index_r <= INDEX_RESET;
		end
		else if (i_ce)
		begin
			active_r <= tbl_r[act];
			if (!i_mono_model)
				active_r.hbin <= HBIN_OFF;
			next_index_r <= i_trig_seq_mode ? tbl_r[act].next_idx : i_active_index;
		end
	end

	assign o_active = active_r;
	assign o_next_index = next_index_r;

	////////////////////////////////////////////////////////////////////////
	// assertions

	// selected entry, read straight from the table
	wire param_set_t cur = tbl_r[sel];

	property p_wr_field(logic [7:0] a);
		@(posedge i_clk) disable iff (i_reset)
		i_ce && done && i_pwrite && i_paddr == a && index_r == $past(index_r);
	endproperty

	a_height_write_lands: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && done && i_pwrite && i_paddr == ADDR_HEIGHT && !pslverr_r
		|=> cur.height == $past(i_pwdata[10:0]))
		else $error("height write did not land");

	a_voff_range_err: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && first_cycle && i_pwrite && i_paddr == ADDR_VOFF && i_pwdata > 32'h4be
		|=> o_pready && o_pslverr)
		else $error("vertical offset above limit not refused");

	a_gain_low_err: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && first_cycle && i_pwrite && i_paddr == ADDR_GAIN && i_pwdata < 32'h64
		|=> o_pslverr)
		else $error("gain below limit not refused");

	a_expo_limits: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && first_cycle && i_pwrite && i_paddr == ADDR_EXPOSURE
		&& i_pwdata >= 32'hf && i_pwdata <= 32'h7a1200
		|=> !o_pslverr)
		else $error("legal exposure refused");

	a_colour_no_bin: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && !i_mono_model |=> o_active.hbin == HBIN_OFF)
		else $error("binning passed through on colour model");

	a_next_mode_gate: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && !i_trig_seq_mode |=> o_next_index == $past(i_active_index))
		else $error("next index used outside trigger sequence");

	a_width_reject_hold: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && done && i_pwrite && i_paddr == ADDR_WIDTH && pslverr_r
		|=> cur.width == $past(cur.width))
		else $error("refused width write changed the table");

	a_read_one_wait: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && first_cycle && !i_pwrite && i_paddr == ADDR_HBIN
		|=> o_pready && o_prdata == {30'h0, $past(cur.hbin)})
		else $error("binning query wrong or late");

	a_hbin_code_err: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && first_cycle && i_pwrite && i_paddr == ADDR_HBIN
		&& (i_pwdata == 32'h0 || i_pwdata > 32'h2)
		|=> o_pslverr)
		else $error("illegal binning code not refused");

	a_width_range_err: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && first_cycle && i_pwrite && i_paddr == ADDR_WIDTH
		&& (i_pwdata < 32'h60 || i_pwdata > 32'h790)
		|=> o_pready && o_pslverr)
		else $error("width outside limits not refused");

	// the upper bound follows the table size, not a fixed count
	a_next_range_err: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && first_cycle && i_pwrite && i_paddr == ADDR_NEXT
		&& (i_pwdata == 32'h0 || i_pwdata > 32'(NUM_IDX))
		|=> o_pready && o_pslverr)
		else $error("next index outside limits not refused");

	a_reject_flag_set: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && done && i_pwrite && pslverr_r
		|=> reject_r)
		else $error("refusal flag not raised");

	c_height_write: cover property (p_wr_field(ADDR_HEIGHT));
	c_rejected_write: cover property (@(posedge i_clk) disable iff (i_reset) done && i_pwrite && pslverr_r);
	c_trig_chain: cover property (@(posedge i_clk) disable iff (i_reset) i_trig_seq_mode && o_next_index != 8'h1);
	c_unmapped_read: cover property (
		@(posedge i_clk) disable iff (i_reset) done && !i_pwrite && !addr_mapped(i_paddr));

endmodule
`default_nettype wire

// [host_apb.sv]
// apb host model issuing set and query transfers
`default_nettype none
module host_apb (
	// clock
	input wire logic i_clk,
	// apb answer
	input wire logic [31:0] i_prdata,
	input wire logic i_pready,
	input wire logic i_pslverr,
	// apb request
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [7:0] o_paddr,
	output logic [31:0] o_pwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0;
	end
	// set is a write, query a read
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err, output logic tmo);
		int n;
		n = 0;
		@(posedge i_clk);
		o_psel <= 1'b1;
		o_pwrite <= wr;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_clk);
		o_penable <= 1'b1;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (i_pready !== 1'b1 && n < 16);
		tmo = (n >= 16);
		rd = i_prdata;
		err = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		// scramble released lines so stale values cannot pass
		o_pwdata <= ~d;
		o_paddr <= ~a;
	endtask
endmodule
`default_nettype wire

// [tb_seq_roi_param_table.sv]
// testbench for the sequenced roi parameter table
`default_nettype none
module tb_seq_roi_param_table;
	import seq_roi_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic mono = 1'b0;
	logic trig = 1'b0;
	logic [7:0] act_idx = 8'h1;
	logic ce = 1'b1;
	param_set_t active;
	logic [7:0] next_idx;
	int mismatches = 0;
	int check_count = 0;
	logic [7:0] fa [7] = '{ADDR_HEIGHT, ADDR_VOFF, ADDR_GAIN, ADDR_EXPOSURE, ADDR_HBIN, ADDR_WIDTH, ADDR_NEXT};
	logic [31:0] fmin [7] = '{32'h2, 32'h0, 32'h64, 32'hf, 32'h1, 32'h60, 32'h1};
	logic [31:0] fmax [7] = '{32'h4c0, 32'h4be, 32'h640, 32'h7a1200, 32'h2, 32'h790, 32'h80};
	logic [31:0] frst [7] = '{32'h4c0, 32'h0, 32'h0, 32'h4650, 32'h1, 32'h790, 32'h1};

	always #20 clk = ~clk;

	host_apb host (.i_clk(clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr), .o_psel(psel),
		.o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

	seq_roi_param_table #(.NUM_IDX(128)) DUT (.i_clk(clk), .i_reset(reset), .i_ce(ce), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_mono_model(mono), .i_trig_seq_mode(trig),
		.i_active_index(act_idx), .o_active(active), .o_next_index(next_idx));

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// expects the error flag, and read data on a read
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic eerr,
		input logic [31:0] ed);
		logic [31:0] rd;
		logic err, tmo;
		host.xfer(wr, a, d, rd, err, tmo);
		if (tmo)
		begin
			mismatches++;
			give_verdict();
		end
		else
		begin
			chk({31'h0, err}, {31'h0, eerr});
			if (!wr)
				chk(rd, ed);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		acc(1'b1, ADDR_INDEX, 32'h5, 1'b0, 32'h0);
		for (int i = 0; i < 7; i++)
		begin
			acc(1'b0, fa[i], 32'h0, 1'b0, frst[i]);
			acc(1'b1, fa[i], fmax[i] + 32'h1, 1'b1, 32'h0);
			acc(1'b1, fa[i], fmin[i] - 32'h1, 1'b1, 32'h0);
			acc(1'b0, fa[i], 32'h0, 1'b0, frst[i]);
			acc(1'b1, fa[i], fmin[i], 1'b0, 32'h0);
			acc(1'b0, fa[i], 32'h0, 1'b0, fmin[i]);
			acc(1'b1, fa[i], fmax[i], 1'b0, 32'h0);
			acc(1'b0, fa[i], 32'h0, 1'b0, fmax[i]);
		end
		acc(1'b1, ADDR_INDEX, 32'h1, 1'b0, 32'h0);
		for (int i = 0; i < 7; i++)
			acc(1'b0, fa[i], 32'h0, 1'b0, frst[i]);
		// refused write then status shows refusal and model bits
		@(posedge clk) mono <= 1'b1;
		acc(1'b1, ADDR_HEIGHT, 32'h1, 1'b1, 32'h0);
		acc(1'b0, ADDR_STATUS, 32'h0, 1'b0, 32'h5);
		acc(1'b0, 8'h24, 32'h0, 1'b1, 32'h0);
		acc(1'b1, ADDR_STATUS, 32'h0, 1'b1, 32'h0);
		// index 5 now holds every maximum
		@(posedge clk) act_idx <= 8'h5;
		repeat (3) @(posedge clk);
		chk({30'h0, active.hbin}, {30'h0, HBIN_X2});
		chk({21'h0, active.height}, 32'h4c0);
		chk({21'h0, active.voff}, 32'h4be);
		chk({21'h0, active.gain}, 32'h640);
		chk({9'h0, active.exposure}, 32'h7a1200);
		chk({21'h0, active.width}, 32'h790);
		chk({24'h0, next_idx}, 32'h5);
		mono <= 1'b0;
		trig <= 1'b1;
		repeat (3) @(posedge clk);
		chk({30'h0, active.hbin}, {30'h0, HBIN_OFF});
		chk({24'h0, next_idx}, 32'h80);
		// clock enable low must freeze the lookup
		ce <= 1'b0;
		act_idx <= 8'h1;
		repeat (3) @(posedge clk);
		chk({24'h0, next_idx}, 32'h80);
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		chk({24'h0, next_idx}, 32'h1);
		// reset in mid-run restores the index and the exposure of entry 5
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		acc(1'b0, ADDR_INDEX, 32'h0, 1'b0, {24'h0, INDEX_RESET});
		acc(1'b1, ADDR_INDEX, 32'h5, 1'b0, 32'h0);
		acc(1'b0, ADDR_EXPOSURE, 32'h0, 1'b0, 32'h4650);
		give_verdict();
	end
endmodule
`default_nettype wire
